// ===== drive_status_consts.svh
`ifndef DRIVE_STATUS_CONSTS_SVH
`define DRIVE_STATUS_CONSTS_SVH

// Register byte offsets
`define OFF_RELAY_SEL   8'h00
`define OFF_TERM_SEL    8'h04
`define OFF_THRESHOLD   8'h08
`define OFF_AIN_FORMAT  8'h0c
`define OFF_STATUS      8'h10
`define OFF_FAULT_CLR   8'h14

// Reset values
`define RST_RELAY_SEL   3'h1
`define RST_TERM_SEL    4'h8
`define RST_THRESHOLD   16'h0000
`define RST_AIN_FORMAT  3'h0

// Field positions in the status word and the fault clear word
`define ST_RELAY_BIT    0
`define ST_DOUT_BIT     1
`define ST_ANALOG_BIT   2
`define ST_TRIP_BIT     3
`define ST_LOSS_BIT     4
`define ST_STOP_BIT     5
`define ST_CODE_LSB     8
`define FAULT_CLR_BIT   0

// Loss threshold in microamps (3 mA)
`define LOSS_UA         16'h0bb8

// Input loss fault code, value arbitrary
`define CODE_INPUT_LOSS 8'h01
`define CODE_NONE       8'h00

// Terminal settings with analog output
`define TERM_FREQ       4'h8
`define TERM_CURR       4'h9

// Bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ===== drive_status_pkg.sv
package drive_status_pkg;

  typedef enum logic [2:0] {
    FN_RUNNING   = 3'b000,
    FN_READY     = 3'b001,
    FN_AT_TARGET = 3'b010,
    FN_TRIPPED   = 3'b011,
    FN_FREQ_GE   = 3'b100,
    FN_CURR_GE   = 3'b101,
    FN_FREQ_LT   = 3'b110,
    FN_CURR_LT   = 3'b111
  } relay_fn_e;

  typedef enum logic [2:0] {
    AIN_V_UNI    = 3'b000,
    AIN_V_BI     = 3'b001,
    AIN_I_0_20   = 3'b010,
    AIN_I_TRIP   = 3'b011,
    AIN_I_RAMP   = 3'b100,
    AIN_INV_TRIP = 3'b101,
    AIN_INV_RAMP = 3'b110
  } ain_fmt_e;

  typedef struct packed {
    logic        running;
    logic        powered;
    logic        fault;
    logic [15:0] out_freq;
    logic [15:0] setpoint;
    logic [15:0] current;
  } drive_state_s;

  typedef struct packed {
    logic        ready;
    logic        tripped;
    logic [15:0] threshold;
  } cond_ctx_s;

endpackage

// ===== status_cond_select.sv
`timescale 1ns/100ps
`default_nettype none
module status_cond_select
  import drive_status_pkg::*;
(
  // Selection
  input  wire logic [2:0]   sel,
  // Drive state
  input  wire drive_state_s st,
  input  wire cond_ctx_s    ctx,
  // Result
  output logic              cond
);

  wire freq_ge = st.out_freq >= ctx.threshold;
  wire curr_ge = st.current >= ctx.threshold;

  always_comb begin
    case (relay_fn_e'(sel))
      FN_RUNNING:   cond = st.running;
      FN_READY:     cond = ctx.ready;
      FN_AT_TARGET: cond = st.out_freq == st.setpoint;
      FN_TRIPPED:   cond = ctx.tripped;
      FN_FREQ_GE:   cond = freq_ge;
      FN_CURR_GE:   cond = curr_ge;
      FN_FREQ_LT:   cond = !freq_ge;
      FN_CURR_LT:   cond = !curr_ge;
      default:      cond = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ===== input_loss_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "drive_status_consts.svh"
module input_loss_monitor
  import drive_status_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Configuration
  input  wire logic [2:0]  fmt,
  input  wire logic        clear,
  // Loop current in microamps
  input  wire logic [15:0] ain_ua,
  // Reactions
  output logic             loss_trip,
  output logic             stop_req
);

  wire below     = ain_ua < `LOSS_UA;
  wire trip_fmt  = fmt == AIN_I_TRIP || fmt == AIN_INV_TRIP;
  wire ramp_fmt  = fmt == AIN_I_RAMP || fmt == AIN_INV_RAMP;
  wire set_trip  = below && trip_fmt;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      loss_trip <= 1'b0;
      stop_req  <= 1'b0;
    end else begin
      // Set wins over clear
      if (set_trip) begin
        loss_trip <= 1'b1;
      end else if (clear) begin
        loss_trip <= 1'b0;
      end
      stop_req <= below && ramp_fmt;
    end
  end

endmodule
`default_nettype wire

// ===== drive_status_output_selector.sv
// How it works
// - A setting register picks one of eight conditions, codes 0 to 7.
// - The relay is active, contacts linked, while that condition holds.
// - Code 0 holds while the drive stage is enabled and running.
// - Code 1 holds while powered and no fault is present.
// - Code 2 holds when output frequency equals the setpoint.
// - Code 3 holds while the drive is tripped.
// - Code 4 holds when output frequency is at or above the threshold.
// - Code 5 holds when motor current is at or above the threshold.
// - Code 6 holds when output frequency is below the threshold.
// - Code 7 holds when motor current is below the threshold.
// - A second register picks what the output terminal shows.
// - Terminal settings 0 to 7 give a digital level, high at full level.
// - Ramp formats request a stop while the loop drops under 3 mA.
// - Trip formats fault and show the input loss code under 3 mA.
// - Terminal settings 8 and 9 give an analog level instead.
`timescale 1ns/100ps
`default_nettype none
`include "drive_status_consts.svh"
module drive_status_output_selector
  import drive_status_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Drive state
  input  wire drive_state_s drive_state,
  input  wire logic [15:0]  ain_ua,
  // AXI4-Lite write address
  input  wire logic [7:0]   awaddr,
  input  wire logic [2:0]   awprot,
  input  wire logic         awvalid,
  output logic              awready,
  // AXI4-Lite write data
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  input  wire logic         wvalid,
  output logic              wready,
  // AXI4-Lite write response
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  wire logic         bready,
  // AXI4-Lite read address
  input  wire logic [7:0]   araddr,
  input  wire logic [2:0]   arprot,
  input  wire logic         arvalid,
  output logic              arready,
  // AXI4-Lite read data
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  wire logic         rready,
  // Status outputs
  output logic              relay_active,
  output logic              dout_level,
  output logic              aout_enable,
  output logic [15:0]       aout_level,
  output logic              tripped,
  output logic              ramp_stop_req,
  output logic [7:0]        input_loss_fault_code
);

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Address decode
  function automatic logic mapped(input logic [7:0] a);
    return a == `OFF_RELAY_SEL || a == `OFF_TERM_SEL ||
           a == `OFF_THRESHOLD || a == `OFF_AIN_FORMAT ||
           a == `OFF_STATUS || a == `OFF_FAULT_CLR;
  endfunction

  // Configuration registers
  logic [2:0]  relay_sel;
  logic [3:0]  term_sel;
  logic [15:0] threshold;
  logic [2:0]  ain_format;

  // Write channel state
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  // Loss monitor results
  logic        loss_trip;
  logic        stop_req;

  // Selector results
  logic        relay_cond;
  logic        term_cond;

  // Handshakes
  wire aw_fire  = awvalid && awready;
  wire w_fire   = wvalid && wready;
  wire ar_fire  = arvalid && arready;
  wire do_write = aw_held && w_held && !bvalid;

  // Next handshake state
  wire next_aw_held = aw_held ? !do_write : aw_fire;
  wire next_w_held  = w_held ? !do_write : w_fire;
  wire next_bvalid  = do_write || (bvalid && !bready);
  wire next_rvalid  = ar_fire || (rvalid && !rready);

  // Register write strobes
  wire wr_relay = do_write && aw_addr_q == `OFF_RELAY_SEL;
  wire wr_term  = do_write && aw_addr_q == `OFF_TERM_SEL;
  wire wr_thr   = do_write && aw_addr_q == `OFF_THRESHOLD;
  wire wr_fmt   = do_write && aw_addr_q == `OFF_AIN_FORMAT;
  wire wr_clr   = do_write && aw_addr_q == `OFF_FAULT_CLR;

  // Register words and merged writes
  wire [31:0] relay_word = {29'h0, relay_sel};
  wire [31:0] term_word  = {28'h0, term_sel};
  wire [31:0] thr_word   = {16'h0, threshold};
  wire [31:0] fmt_word   = {29'h0, ain_format};
  wire [31:0] relay_new  = merge(relay_word, w_data_q, w_strb_q);
  wire [31:0] term_new   = merge(term_word, w_data_q, w_strb_q);
  wire [31:0] thr_new    = merge(thr_word, w_data_q, w_strb_q);
  wire [31:0] fmt_new    = merge(fmt_word, w_data_q, w_strb_q);
  wire [31:0] clr_new    = merge(32'h0000_0000, w_data_q, w_strb_q);
  wire        fault_clr  = wr_clr && clr_new[`FAULT_CLR_BIT];

  // Fault state and derived conditions
  wire trip_now  = drive_state.fault || loss_trip;
  wire ready_now = drive_state.powered && !trip_now;

  cond_ctx_s ctx;
  assign ctx.ready     = ready_now;
  assign ctx.tripped   = trip_now;
  assign ctx.threshold = threshold;

  // Terminal mode decode
  wire term_digital = term_sel[3] == 1'b0;
  wire term_freq    = term_sel == `TERM_FREQ;
  wire term_curr    = term_sel == `TERM_CURR;
  wire term_analog  = term_freq || term_curr;
  wire [15:0] next_aout = term_freq ? drive_state.out_freq :
                          term_curr ? drive_state.current :
                          16'h0000;

  // Fault code while the loss trip is latched
  wire [7:0] code_now = loss_trip ? `CODE_INPUT_LOSS : `CODE_NONE;

  // Response codes
  wire [1:0] wr_resp = mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
  wire [1:0] rd_resp = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;

  // Status word
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`ST_RELAY_BIT]  = relay_active;
    status_word[`ST_DOUT_BIT]   = dout_level;
    status_word[`ST_ANALOG_BIT] = aout_enable;
    status_word[`ST_TRIP_BIT]   = tripped;
    status_word[`ST_LOSS_BIT]   = loss_trip;
    status_word[`ST_STOP_BIT]   = stop_req;
    status_word[`ST_CODE_LSB +: 8] = input_loss_fault_code;
  end

  // Read mux
  wire [31:0] read_word =
    araddr == `OFF_RELAY_SEL  ? relay_word :
    araddr == `OFF_TERM_SEL   ? term_word  :
    araddr == `OFF_THRESHOLD  ? thr_word   :
    araddr == `OFF_AIN_FORMAT ? fmt_word   :
    araddr == `OFF_STATUS     ? status_word :
    32'h0000_0000;

  // Relay condition selector
  status_cond_select u_relay_sel (
    .sel  (relay_sel),
    .st   (drive_state),
    .ctx  (ctx),
    .cond (relay_cond)
  );

  // Terminal condition selector, same condition set
  status_cond_select u_term_sel (
    .sel  (term_sel[2:0]),
    .st   (drive_state),
    .ctx  (ctx),
    .cond (term_cond)
  );

  // Current loop loss reactions
  input_loss_monitor u_loss (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .fmt       (ain_format),
    .clear     (fault_clr),
    .ain_ua    (ain_ua),
    .loss_trip (loss_trip),
    .stop_req  (stop_req)
  );

  // Bus handshake state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rresp   <= `RESP_OKAY;
      rdata   <= 32'h0000_0000;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      awready <= !next_aw_held && !next_bvalid;
      wready  <= !next_w_held && !next_bvalid;
      bvalid  <= next_bvalid;
      if (do_write) begin
        bresp <= wr_resp;
      end
      arready <= !next_rvalid;
      rvalid  <= next_rvalid;
      if (ar_fire) begin
        rdata <= read_word;
        rresp <= rd_resp;
      end
    end
  end

  // Captured write address and data
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_addr_q <= awaddr;
      end
      if (w_fire) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      relay_sel  <= `RST_RELAY_SEL;
      term_sel   <= `RST_TERM_SEL;
      threshold  <= `RST_THRESHOLD;
      ain_format <= `RST_AIN_FORMAT;
    end else begin
      if (wr_relay) begin
        relay_sel <= relay_new[2:0];
      end
      if (wr_term) begin
        term_sel <= term_new[3:0];
      end
      if (wr_thr) begin
        threshold <= thr_new[15:0];
      end
      if (wr_fmt) begin
        ain_format <= fmt_new[2:0];
      end
    end
  end

  // Status outputs, refreshed every cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      relay_active          <= 1'b0;
      dout_level            <= 1'b0;
      aout_enable           <= 1'b0;
      aout_level            <= 16'h0000;
      tripped               <= 1'b0;
      ramp_stop_req         <= 1'b0;
      input_loss_fault_code <= `CODE_NONE;
    end else begin
      relay_active          <= relay_cond;
      dout_level            <= term_digital && term_cond;
      aout_enable           <= term_analog;
      aout_level            <= next_aout;
      tripped               <= trip_now;
      ramp_stop_req         <= stop_req;
      input_loss_fault_code <= code_now;
    end
  end

endmodule
`default_nettype wire

// ===== drive_status_output_selector_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "drive_status_consts.svh"
module drive_status_output_selector_checker
  import drive_status_pkg::*;
(
  // Clock and reset
  input wire logic         mclk,
  input wire logic         rst_n,
  // Drive side
  input wire drive_state_s drive_state,
  input wire logic [15:0]  ain_ua,
  // Bus
  input wire logic         awvalid,
  input wire logic         awready,
  input wire logic         wvalid,
  input wire logic         wready,
  input wire logic [1:0]   bresp,
  input wire logic         bvalid,
  input wire logic         bready,
  input wire logic         arvalid,
  input wire logic         arready,
  input wire logic [31:0]  rdata,
  input wire logic         rvalid,
  input wire logic         rready,
  // Status
  input wire logic         dout_level,
  input wire logic         aout_enable,
  input wire logic         tripped,
  input wire logic         ramp_stop_req,
  input wire logic [7:0]   input_loss_fault_code
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence

  property p_fault_trips;
    drive_state.fault [*3] |-> tripped;
  endproperty
  a_fault_trips: assert property (p_fault_trips)
    else $error("fault input not shown as tripped");
  property p_code_trip;
    input_loss_fault_code != `CODE_NONE |->
      tripped && input_loss_fault_code == `CODE_INPUT_LOSS;
  endproperty
  a_code_trip: assert property (p_code_trip)
    else $error("fault code without trip");
  property p_stop_low;
    ramp_stop_req |-> $past(ain_ua, 1) < `LOSS_UA ||
      $past(ain_ua, 2) < `LOSS_UA || $past(ain_ua, 3) < `LOSS_UA;
  endproperty
  a_stop_low: assert property (p_stop_low)
    else $error("stop request without low loop");
  property p_stop_drop;
    ain_ua >= `LOSS_UA [*4] |-> !ramp_stop_req;
  endproperty
  a_stop_drop: assert property (p_stop_drop)
    else $error("stop request held with loop present");
  property p_term_excl;
    aout_enable |-> !dout_level;
  endproperty
  a_term_excl: assert property (p_term_excl)
    else $error("digital level while analog selected");
  property p_wr_resp;
    s_wr_take |=> !bvalid ##1 bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response timing wrong");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_rd_resp;
    s_rd_take |=> rvalid && !arready;
  endproperty
  a_rd_resp: assert property (p_rd_resp)
    else $error("read answer timing wrong");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
endmodule

bind drive_status_output_selector drive_status_output_selector_checker i_chk (
  .mclk(mclk), .rst_n(rst_n), .drive_state(drive_state), .ain_ua(ain_ua),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .dout_level(dout_level), .aout_enable(aout_enable), .tripped(tripped),
  .ramp_stop_req(ramp_stop_req),
  .input_loss_fault_code(input_loss_fault_code));
`default_nettype wire

// ===== drive_status_output_selector_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "drive_status_consts.svh"
module drive_status_output_selector_tb
  import drive_status_pkg::*;
;
  localparam logic [1:0] OK  = `RESP_OKAY;
  localparam logic [1:0] ERR = `RESP_SLVERR;
  logic         mclk = 1'b0;
  logic         rst_n = 1'b0;
  drive_state_s drive_state = '0;
  logic [15:0]  ain_ua = 16'h0fa0;
  logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]  wdata = 32'h0000_0000;
  logic [3:0]   wstrb = 4'hf, strb = 4'hf;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic         arvalid = 1'b0, rready = 1'b0;
  wire logic    awready, wready, bvalid, arready, rvalid, relay_active;
  wire logic    dout_level, aout_enable, tripped, ramp_stop_req;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] aout_level;
  wire logic [7:0]  input_loss_fault_code;
  logic [33:0]  q[$];
  logic [15:0]  thr = 16'h0000;
  logic [2:0]   rsel = 3'h1;
  logic [3:0]   tsel = 4'h8;
  logic         loss = 1'b0, stop = 1'b0;
  int           fails = 0, n_tests = 0, cyc = 0;

  drive_status_output_selector i_dut (.mclk(mclk), .rst_n(rst_n),
    .drive_state(drive_state), .ain_ua(ain_ua), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .relay_active(relay_active),
    .dout_level(dout_level), .aout_enable(aout_enable),
    .aout_level(aout_level), .tripped(tripped),
    .ramp_stop_req(ramp_stop_req),
    .input_loss_fault_code(input_loss_fault_code));

  initial begin
    forever #4 mclk = ~mclk;
  end

  task automatic end_sim();
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    n_tests++;
    if (s !== e || $isunknown(e)) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic take(input logic [33:0] s);
    if (q.size() == 0) chk(s, 'x);
    else chk(s, q.pop_front());
  endtask

  // Result watcher
  always @(posedge mclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) take({rresp, rdata});
    if (bvalid === 1'b1 && bready === 1'b1) take({bresp, 32'h0});
    cyc++;
    if (cyc == 30000) begin
      fails++;
      end_sim();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    q.push_back({r, 32'h0000_0000});
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= strb;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    repeat ($urandom_range(2)) @(posedge mclk);
    bready <= 1'b1;
    @(posedge mclk);
    bready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    q.push_back({r, d});
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    repeat ($urandom_range(2)) @(posedge mclk);
    rready <= 1'b1;
    @(posedge mclk);
    rready <= 1'b0;
    @(posedge mclk);
  endtask

  function automatic logic cond(input logic [2:0] s);
    case (s)
      3'h0: cond = drive_state.running;
      3'h1: cond = drive_state.powered & ~(drive_state.fault | loss);
      3'h2: cond = drive_state.out_freq == drive_state.setpoint;
      3'h3: cond = drive_state.fault | loss;
      3'h4: cond = drive_state.out_freq >= thr;
      3'h5: cond = drive_state.current >= thr;
      3'h6: cond = drive_state.out_freq < thr;
      default: cond = drive_state.current < thr;
    endcase
  endfunction

  task automatic check_all();
    logic        dv;
    logic        ae;
    logic [15:0] al;
    repeat (4) @(posedge mclk);
    dv = tsel < 4'h8 && cond(tsel[2:0]);
    ae = tsel == `TERM_FREQ || tsel == `TERM_CURR;
    al = tsel == `TERM_FREQ ? drive_state.out_freq :
         tsel == `TERM_CURR ? drive_state.current : 16'h0000;
    chk({5'h00, relay_active, dout_level, aout_enable, tripped, ramp_stop_req,
         input_loss_fault_code, aout_level}, {5'h00, cond(rsel), dv, ae,
         drive_state.fault | loss, stop, 7'h00, loss, al});
    rd(8'h10, {23'h00_0000, loss, 2'h0, stop, loss, drive_state.fault | loss,
       ae, dv, cond(rsel)}, OK);
  endtask

  initial begin
    void'($urandom(92));
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(8'h00, 32'h0000_0001, OK);
    rd(8'h04, 32'h0000_0008, OK);
    rd(8'h18, 32'h0000_0000, ERR);
    wr(8'h18, 32'h0000_0007, ERR);
    strb = 4'h2;
    wr(8'h08, 32'h0000_ab12, OK);
    strb = 4'hf;
    rd(8'h08, 32'h0000_ab00, OK);
    for (int i = 0; i < 16; i++) begin
      thr = 16'($urandom_range(16'hfff0, 16'h0010));
      drive_state <= '{1'($urandom_range(1)), 1'($urandom_range(1)),
        1'($urandom_range(1)), 16'(thr + $urandom_range(2) - 1),
        16'(thr + $urandom_range(1)), 16'(thr + $urandom_range(2) - 1)};
      rsel = i[2:0];
      tsel = i[3:0];
      wr(8'h08, {16'h0000, thr}, OK);
      wr(8'h00, {29'h0000_0000, rsel}, OK);
      wr(8'h04, {28'h000_0000, tsel}, OK);
      check_all();
    end
    wr(8'h10, 32'hffff_ffff, OK);
    check_all();
    drive_state <= '0;
    rsel = 3'h3;
    wr(8'h00, 32'h0000_0003, OK);
    for (int i = 0; i < 8; i++) begin
      wr(8'h0c, 32'(i), OK);
      ain_ua <= 16'h0bb7;
      stop = i == 4 || i == 6;
      loss = i == 3 || i == 5;
      check_all();
      ain_ua <= 16'h0bb8;
      stop = 1'b0;
      check_all();
      wr(8'h14, 32'h0000_0001, OK);
      loss = 1'b0;
      check_all();
    end
    // Clear while the loop is still lost: the trip stays
    wr(8'h0c, 32'h0000_0003, OK);
    ain_ua <= 16'h0bb7;
    loss = 1'b1;
    wr(8'h14, 32'h0000_0001, OK);
    check_all();
    end_sim();
  end
endmodule
`default_nettype wire
